// *** verilog/ssr_host.sv ***
// Purpose: Host end: sends frames, collects replies, watches faults
// Assumes: Software drives the register port; one frame at a time
// Notes:   Command writes while busy are dropped; poll the busy bit
//
// The implementer's own choice: the plain strobed port.
module ssr_host
    import ssr_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RSTN_I,
    ssr_spi_if.host          spi,
    input  wire logic [3:0]  REG_ADDR_I,
    input  wire logic [31:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic [31:0]      REG_RDATA_O,
    output logic             POWER_CYCLE_O
);
    ssr_hstate_t  state_r;
    logic [2:0]   div_r;
    logic [4:0]   bit_r;
    logic [31:0]  tx_r;
    logic [31:0]  rx_r;
    logic [31:0]  cmd_r;
    logic [31:0]  rsp_r;
    logic [31:0]  rdata_r;
    logic [3:0]   ctrl_r;
    logic [7:0]   exceed_cnt_r;
    logic         done_r;
    logic         recover_r;
    logic         crc_err_r;
    logic         seen_sum_r;
    logic         sclk_r;
    logic         cs_n_r;

    wire          busy;
    wire          tick;
    wire          wr_cmd;
    wire          wr_ctrl;
    wire          start;
    wire [31:0]   start_frame;
    wire          rd_stat;
    wire          rsp_done;
    wire          crc_ok;
    wire [15:0]   rsp_data;
    wire          is_sto_rsp;
    wire          is_sum_rsp;
    wire [15:0]   thr;
    wire          exceed;
    wire          need_reset;
    wire [31:0]   stat_word;
    wire [31:0]   rd_mux;

    // Register port decode
    assign busy        = (state_r != H_IDLE);
    assign tick        = (div_r == SCLK_HALF_LAST);
    assign wr_cmd      = REG_WR_I & (REG_ADDR_I == HREG_CMD);
    assign wr_ctrl     = REG_WR_I & (REG_ADDR_I == HREG_CTRL);
    assign start       = ~busy & (wr_cmd | (wr_ctrl & REG_WDATA_I[CTRL_SW_RST]));
    assign start_frame = wr_cmd ? REG_WDATA_I : CMD_SW_RESET;
    assign rd_stat     = REG_RD_I & (REG_ADDR_I == HREG_STAT);

    // Reply checks at frame end
    assign rsp_done   = (state_r == H_TAIL) & tick;
    assign crc_ok     = (rx_r[7:0] == ssr_crc8(rx_r[31:8]));
    assign rsp_data   = rx_r[DATA_MSB:DATA_LSB];
    assign is_sto_rsp = crc_ok & (rx_r[OP_MSB:OP_LSB] == OP_RD_SELF_CHK) &
                        (rx_r[RS_MSB:RS_LSB] == RS_OK);
    assign is_sum_rsp = crc_ok & (rx_r[OP_MSB:OP_LSB] == OP_RD_SUMMARY);

    // Threshold by selected mode, symmetric around zero
    assign thr    = (ctrl_r[1:0] == 2'h0) ? THR_MODE1 :
                    (ctrl_r[1:0] == 2'h1) ? THR_MODE2 : THR_MODE34;
    assign exceed = ($signed(rsp_data) > $signed(thr)) ||
                    ($signed(rsp_data) < -$signed(thr));

    // Faults that call for a reset; supply bit skipped on first summary
    assign need_reset = |(rsp_data & RECOVER_MASK) |
                        (rsp_data[BIT_SUPPLY] & seen_sum_r);

    assign stat_word = {16'h0000, exceed_cnt_r, 4'h0, crc_err_r, recover_r, done_r, busy};
    assign rd_mux    = (REG_ADDR_I == HREG_CMD)  ? cmd_r :
                       (REG_ADDR_I == HREG_RSP)  ? rsp_r :
                       (REG_ADDR_I == HREG_STAT) ? stat_word :
                       (REG_ADDR_I == HREG_CTRL) ? {28'h000_0000, ctrl_r} : 32'h0000_0000;

    // Frame sequencer: lead, 32 clock pulses, tail, gap
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= H_IDLE;
            div_r   <= 3'h0;
            bit_r   <= 5'h00;
            tx_r    <= 32'h0000_0000;
            rx_r    <= 32'h0000_0000;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
        end else begin
            div_r <= (state_r == H_IDLE || tick) ? 3'h0 : div_r + 3'h1;
            case (state_r)
                H_IDLE: begin
                    if (start) begin
                        tx_r    <= start_frame;
                        bit_r   <= 5'h00;
                        cs_n_r  <= 1'b0;
                        state_r <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (tick) begin
                        sclk_r  <= 1'b1;
                        rx_r    <= {rx_r[30:0], spi.miso_line};
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_r <= 1'b0;
                        bit_r  <= bit_r + 5'h01;
                        if (bit_r == 5'h1F) begin
                            state_r <= H_TAIL;
                        end else begin
                            tx_r    <= {tx_r[30:0], 1'b0};
                            state_r <= H_LOW;
                        end
                    end
                end
                H_TAIL: begin
                    if (tick) begin
                        cs_n_r  <= 1'b1;
                        state_r <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tick) begin
                        state_r <= H_IDLE;
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    // Software registers and sticky status, set wins over clear
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cmd_r      <= 32'h0000_0000;
            rsp_r      <= 32'h0000_0000;
            ctrl_r     <= 4'h0;
            done_r     <= 1'b0;
            recover_r  <= 1'b0;
            crc_err_r  <= 1'b0;
            seen_sum_r <= 1'b0;
        end else begin
            if (wr_cmd && !busy) begin
                cmd_r <= REG_WDATA_I;
            end
            if (wr_ctrl) begin
                ctrl_r <= {1'b0, REG_WDATA_I[CTRL_PWR_CYC:0]};
            end
            if (rsp_done) begin
                rsp_r <= rx_r;
            end
            if (rsp_done && is_sum_rsp) begin
                seen_sum_r <= 1'b1;
            end
            done_r    <= rsp_done | (done_r & ~rd_stat);
            recover_r <= (rsp_done & is_sum_rsp & need_reset) | (recover_r & ~rd_stat);
            crc_err_r <= (rsp_done & ~crc_ok) | (crc_err_r & ~rd_stat);
        end
    end

    // Consecutive self-check exceedance counter, saturating
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            exceed_cnt_r <= 8'h00;
        end else if (rsp_done && is_sto_rsp) begin
            exceed_cnt_r <= !exceed ? 8'h00 :
                            (exceed_cnt_r == 8'hFF) ? 8'hFF : exceed_cnt_r + 8'h01;
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= REG_RD_I ? rd_mux : 32'h0000_0000;
        end
    end

    assign REG_RDATA_O   = rdata_r;
    assign POWER_CYCLE_O = ctrl_r[CTRL_PWR_CYC];
    assign spi.sclk      = sclk_r;
    assign spi.cs_n      = cs_n_r;
    assign spi.mosi      = tx_r[31];
endmodule

// *** verilog/ssr_pkg.sv ***
// Purpose: Shared constants, types and CRC for the status/self-check link
// Assumes: One 25 MHz system clock at both ends, 32-bit frames, MSB first
// Notes:   Register table lives here; the host uses it as the far device map
// Functional notes
// - Bank 1 address 04h holds signed self-check word
// - Frame 100000E9h reads the self-check word
// - Address 06h summary, any bank, merges fault details
// - Frame 180000E5h reads the summary word
// - Bits 9,8,7 logic and timebase; 15:10 reserved
// - Bit 5 thermal clip, bit 3 memory fault
// - Bit 4 set after reset, else supply fault
// - Bit 2 high while powered down
// - Bit 1 set when operation mode changed
// - Bit 0 internal connection fault
// - Host resets device on serious faults; here the host only flags them in recover_r (status bit 2)
// - Software reset by command, hardware by power cycle
// - Reply: opcode, status pair, data, CRC
// - Host checks self-check after axis reads; here it checks each self-check reply with good CRC and status pair 01 that software requests
// - Host counts consecutive self-check threshold exceedances
// - Reading summary clears it
// - Status pair 11 while pending, 01 after read
// - Reply comes in the following frame
package ssr_pkg;
    // Frame layout
    localparam int          FRAME_BITS     = 32;
    localparam int          OP_MSB         = 31;
    localparam int          OP_LSB         = 26;
    localparam int          RS_MSB         = 25;
    localparam int          RS_LSB         = 24;
    localparam int          DATA_MSB       = 23;
    localparam int          DATA_LSB       = 8;
    localparam logic [1:0]  RS_OK          = 2'h1;
    localparam logic [1:0]  RS_PENDING     = 2'h3;
    // Device register map (word addresses)
    localparam logic [4:0]  ADDR_SELF_CHECK = 5'h04;
    localparam logic [4:0]  ADDR_SUMMARY    = 5'h06;
    localparam logic [5:0]  OP_RD_SELF_CHK  = {1'b0, ADDR_SELF_CHECK};
    localparam logic [5:0]  OP_RD_SUMMARY   = {1'b0, ADDR_SUMMARY};
    localparam logic [31:0] CMD_RD_SELF_CHK = 32'h1000_00E9;
    localparam logic [31:0] CMD_RD_SUMMARY  = 32'h1800_00E5;
    localparam logic [31:0] CMD_SW_RESET    = 32'hB400_2098;
    // Summary field positions
    localparam int          BIT_LOGIC_A    = 9;
    localparam int          BIT_LOGIC_B    = 8;
    localparam int          BIT_TIMEBASE   = 7;
    localparam int          BIT_CLIP       = 6;
    localparam int          BIT_THERMAL    = 5;
    localparam int          BIT_SUPPLY     = 4;
    localparam int          BIT_NVM        = 3;
    localparam int          BIT_PWR_DOWN   = 2;
    localparam int          BIT_MODE_SW    = 1;
    localparam int          BIT_LINK       = 0;
    localparam int          FLAG_BITS      = 10;
    localparam logic [9:0]  FLAGS_RST      = 10'h010;
    localparam logic [15:0] RECOVER_MASK   = 16'h0388;
    // CRC-8 over the top 24 bits of a frame
    localparam logic [7:0]  CRC_POLY       = 8'h1D;
    localparam logic [7:0]  CRC_INIT       = 8'hFF;
    localparam logic [7:0]  CRC_OUT_XOR    = 8'hFF;
    // Host control registers
    localparam logic [3:0]  HREG_CMD       = 4'h0;
    localparam logic [3:0]  HREG_RSP       = 4'h1;
    localparam logic [3:0]  HREG_STAT      = 4'h2;
    localparam logic [3:0]  HREG_CTRL      = 4'h3;
    localparam int          CTRL_SW_RST    = 3;
    localparam int          CTRL_PWR_CYC   = 2;
    // Self-check thresholds: 1800, 900, 3600, 3600 LSB
    localparam logic [15:0] THR_MODE1      = 16'h0708;
    localparam logic [15:0] THR_MODE2      = 16'h0384;
    localparam logic [15:0] THR_MODE34     = 16'h0E10;
    // Serial clock timing
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          SCLK_HALF_NS   = 160;
    localparam int          SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);

    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP} ssr_hstate_t;

    // Checksum of a frame's first three bytes
    function automatic logic [7:0] ssr_crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c ^ CRC_OUT_XOR;
    endfunction
endpackage

// *** verilog/ssr_spi_if.sv ***
// Purpose: Serial link between host and sensor ends
// Assumes: Host makes the serial clock from its system clock
// Notes:   Reply line idles high when the device is not driving it
interface ssr_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Resolved reply line with pull-up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev  (input sclk, cs_n, mosi, output miso, miso_oe);
    modport host (output sclk, cs_n, mosi, input miso_line);
endinterface

// *** verilog/ssr_device.sv ***
// Purpose: Sensor end: self-check and fault summary registers on the link
// Assumes: Link pins synchronous to CLK_SYS_I, half period of 2+ cycles
// Notes:   Reply to a frame is shifted out during the next frame
module ssr_device
    import ssr_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RSTN_I,
    ssr_spi_if.dev           spi,
    input  wire logic [15:0] SELF_CHECK_I,
    input  wire logic        BANK1_SEL_I,
    input  wire logic        LOGIC_FAULT_A_I,
    input  wire logic        LOGIC_FAULT_B_I,
    input  wire logic        TIMEBASE_FAULT_I,
    input  wire logic        SIGNAL_CLIP_I,
    input  wire logic        THERMAL_CLIP_I,
    input  wire logic        SUPPLY_FAULT_I,
    input  wire logic        NVM_FAULT_I,
    input  wire logic        POWERED_DOWN_I,
    input  wire logic        MODE_SWITCHED_I,
    input  wire logic        LINK_FAULT_I,
    output logic [15:0]      FAULT_SUMMARY_O,
    output logic             REPLY_PENDING_O
);
    logic                  sclk_q_r;
    logic                  cs_n_q_r;
    logic [31:0]           rx_r;
    logic [31:0]           tx_r;
    logic [5:0]            bit_cnt_r;
    logic [31:0]           reply_r;
    logic [31:0]           reply_nxt;
    logic [FLAG_BITS-1:0]  flags_r;
    logic [FLAG_BITS-1:0]  flags_nxt;
    logic [FLAG_BITS-1:0]  evt_prev_r;
    logic                  rs_err_r;
    logic                  rs_err_nxt;

    wire [FLAG_BITS-1:0]   evt_vec;
    wire [FLAG_BITS-1:0]   evt_rise;
    wire                   sclk_rise;
    wire                   sclk_fall;
    wire                   cs_fall;
    wire                   cs_rise;
    wire                   frame_done;
    wire                   is_self_chk;
    wire                   is_summary;
    wire                   summary_read;
    wire [15:0]            summary_word;
    wire [15:0]            reply_data;
    wire [1:0]             reply_rs;
    wire [23:0]            reply_head;

    // Event levels mapped onto summary bit positions
    assign evt_vec[BIT_LOGIC_A]  = LOGIC_FAULT_A_I;
    assign evt_vec[BIT_LOGIC_B]  = LOGIC_FAULT_B_I;
    assign evt_vec[BIT_TIMEBASE] = TIMEBASE_FAULT_I;
    assign evt_vec[BIT_CLIP]     = SIGNAL_CLIP_I;
    assign evt_vec[BIT_THERMAL]  = THERMAL_CLIP_I;
    assign evt_vec[BIT_SUPPLY]   = SUPPLY_FAULT_I;
    assign evt_vec[BIT_NVM]      = NVM_FAULT_I;
    assign evt_vec[BIT_PWR_DOWN] = POWERED_DOWN_I;
    assign evt_vec[BIT_MODE_SW]  = MODE_SWITCHED_I;
    assign evt_vec[BIT_LINK]     = LINK_FAULT_I;
    assign evt_rise              = evt_vec & ~evt_prev_r;

    // Link edge detection against last sampled pin levels
    assign sclk_rise  = spi.sclk & ~sclk_q_r;
    assign sclk_fall  = ~spi.sclk & sclk_q_r;
    assign cs_fall    = ~spi.cs_n & cs_n_q_r;
    assign cs_rise    = spi.cs_n & ~cs_n_q_r;
    assign frame_done = cs_rise & (bit_cnt_r == 6'(FRAME_BITS));

    // Command decode on complete frames only
    assign is_self_chk  = (rx_r == CMD_RD_SELF_CHK);
    assign is_summary   = (rx_r == CMD_RD_SUMMARY);
    assign summary_read = frame_done & is_summary;

    // Reserved bits forced low, summary independent of bank
    assign summary_word = {6'h00, flags_r};

    // Reply data select; self-check only visible in bank 1
    assign reply_data = (is_self_chk & BANK1_SEL_I) ? SELF_CHECK_I :
                        is_summary ? summary_word : 16'h0000;
    assign reply_rs   = rs_err_r ? RS_PENDING : RS_OK;
    assign reply_head = {rx_r[OP_MSB:OP_LSB], reply_rs, reply_data};
    assign reply_nxt  = {reply_head, ssr_crc8(reply_head)};

    // Sticky flags; a new event wins over the read clear
    assign flags_nxt  = (summary_read ? '0 : flags_r) | evt_vec;
    assign rs_err_nxt = (summary_read ? 1'b0 : rs_err_r) | (|evt_rise);

    // Pin sampling for edge detection
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sclk_q_r <= 1'b0;
            cs_n_q_r <= 1'b1;
        end else begin
            sclk_q_r <= spi.sclk;
            cs_n_q_r <= spi.cs_n;
        end
    end

    // Command shift-in and bit count
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_r      <= 32'h0000_0000;
            bit_cnt_r <= 6'h00;
        end else if (cs_fall) begin
            bit_cnt_r <= 6'h00;
        end else if (sclk_rise && !spi.cs_n) begin
            rx_r      <= {rx_r[30:0], spi.mosi};
            bit_cnt_r <= (bit_cnt_r == 6'h3F) ? bit_cnt_r : bit_cnt_r + 6'h01;
        end
    end

    // Reply is built at frame end and held for the next frame
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            reply_r <= 32'h0000_0000;
        end else if (frame_done) begin
            reply_r <= reply_nxt;
        end
    end

    // Reply shift-out, changed on falling clock
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx_r <= 32'h0000_0000;
        end else if (cs_fall) begin
            tx_r <= reply_r;
        end else if (sclk_fall && !spi.cs_n) begin
            tx_r <= {tx_r[30:0], 1'b0};
        end
    end

    // Fault flags and return-status state
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flags_r    <= FLAGS_RST;
            rs_err_r   <= 1'b1;
            evt_prev_r <= '0;
        end else begin
            flags_r    <= flags_nxt;
            rs_err_r   <= rs_err_nxt;
            evt_prev_r <= evt_vec;
        end
    end

    // Link outputs
    assign spi.miso    = tx_r[31];
    assign spi.miso_oe = ~cs_n_q_r;

    // Local status view
    assign FAULT_SUMMARY_O = summary_word;
    assign REPLY_PENDING_O = rs_err_r;
endmodule

// *** tb/ssr_chk.sv ***
// Purpose: Wire checks on the host/sensor serial link
// Assumes: Both ends on one clock, async active-low reset
// Notes:   Sees interface signals only, beside the link instance
module ssr_chk (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_line
);
    logic [5:0] rise_cnt_r;
    logic       sclk_q_r;

    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    // Serial clock rises counted inside a frame
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rise_cnt_r <= 6'h00;
            sclk_q_r   <= 1'b0;
        end else begin
            sclk_q_r   <= sclk;
            rise_cnt_r <= cs_n ? 6'h00 : rise_cnt_r + {5'h00, sclk & ~sclk_q_r};
        end
    end

    // Frame shape and reply drive
    AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt_r == 6'h20)
        else $error("frame closed without 32 clock rises");
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
        else $error("command bit changed while clock high");
    AST_MISO_HOLD: assert property (sclk && miso_oe |-> $stable(miso))
        else $error("reply bit changed while clock high");
    AST_OE_ON: assert property ($fell(cs_n) |=> miso_oe)
        else $error("reply line not driven after frame start");
    AST_OE_HELD: assert property (!cs_n && !$fell(cs_n) |-> miso_oe)
        else $error("reply line released inside a frame");
    AST_OE_OFF: assert property ($rose(cs_n) |=> !miso_oe && miso_line)
        else $error("reply line still driven after frame end");
    AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("frame gap too short");
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for host and sensor ends on one link
// Assumes: 25 MHz clock; frames started and polled through host registers
// Notes:   Replies land one frame late, so checks expect the earlier command
module tb import ssr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, wr, rd, bank1, pwr_cyc, pend_o;
    logic [3:0]  addr;
    logic [9:0]  flt;
    logic [15:0] self_chk, sum_o;
    logic [31:0] wdata, rdata, got, stat_acc;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;

    ssr_spi_if u_ssr_spi_if ();

    ssr_device u_ssr_device (
        .CLK_SYS_I(clk), .RSTN_I(rst_n), .spi(u_ssr_spi_if.dev),
        .SELF_CHECK_I(self_chk), .BANK1_SEL_I(bank1),
        .LOGIC_FAULT_A_I(flt[9]), .LOGIC_FAULT_B_I(flt[8]), .TIMEBASE_FAULT_I(flt[7]),
        .SIGNAL_CLIP_I(flt[6]), .THERMAL_CLIP_I(flt[5]), .SUPPLY_FAULT_I(flt[4]),
        .NVM_FAULT_I(flt[3]), .POWERED_DOWN_I(flt[2]), .MODE_SWITCHED_I(flt[1]),
        .LINK_FAULT_I(flt[0]), .FAULT_SUMMARY_O(sum_o), .REPLY_PENDING_O(pend_o));

    ssr_host u_ssr_host (
        .CLK_SYS_I(clk), .RSTN_I(rst_n), .spi(u_ssr_spi_if.host),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .POWER_CYCLE_O(pwr_cyc));

    ssr_chk u_ssr_chk (
        .CLK_SYS_I(clk), .RSTN_I(rst_n), .sclk(u_ssr_spi_if.sclk),
        .cs_n(u_ssr_spi_if.cs_n), .mosi(u_ssr_spi_if.mosi), .miso(u_ssr_spi_if.miso),
        .miso_oe(u_ssr_spi_if.miso_oe), .miso_line(u_ssr_spi_if.miso_line));

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Expected reply word: echo, status pair, data, checksum
    function automatic logic [31:0] reply(input logic [5:0] op, input logic [1:0] rs,
                                          input logic [15:0] d);
        logic [23:0] w;
        logic [7:0]  c;
        w = {op, rs, d};
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
        return {w, c ^ CRC_OUT_XOR};
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Poll busy, gathering every status word seen
    task automatic wait_idle();
        logic [31:0] s;
        stat_acc = 32'h0000_0000;
        for (int i = 0; i < 400; i++) begin
            reg_rd(HREG_STAT, s);
            stat_acc = stat_acc | s;
            if (s[0] === 1'b0)
                break;
        end
    endtask

    task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp);
        reg_wr(HREG_CMD, cmd);
        wait_idle();
        reg_rd(HREG_RSP, rsp);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        self_chk = 16'h0000;
        bank1 = 1'b1;
        flt = 10'h000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset summary", {16'h0000, sum_o}, 32'h0000_0010);
        check("reset pending", {31'h0000_0000, pend_o}, 32'h0000_0001);
        reg_wr(HREG_CTRL, 32'h0000_0004);
        reg_rd(HREG_CTRL, got);
        check("ctrl", got, 32'h0000_0004);
        check("power cycle", {31'h0000_0000, pwr_cyc}, 32'h0000_0001);
        reg_wr(HREG_CTRL, 32'h0000_0000);
        reg_rd(4'h9, got);
        check("unmapped", got, 32'h0000_0000);
        frame(CMD_RD_SUMMARY, got);
        frame(CMD_RD_SUMMARY, got);
        check("start reply", got, reply(OP_RD_SUMMARY, RS_PENDING, 16'h0010));
        check("cleared", {16'h0000, sum_o}, 32'h0000_0000);
        check("pending", {31'h0000_0000, pend_o}, 32'h0000_0000);
        // Each flag pulsed alone, both banks
        for (int i = 0; i < FLAG_BITS; i++) begin
            @(posedge clk);
            flt   <= 10'h001 << i;
            bank1 <= i[0];
            @(posedge clk);
            flt   <= 10'h000;
            repeat (2) @(negedge clk);
            check("flag", {16'h0000, sum_o}, 32'h0000_0001 << i);
            check("pend", {31'h0000_0000, pend_o}, 32'h0000_0001);
            frame(CMD_RD_SUMMARY, got);
            check("clean reply", got, reply(OP_RD_SUMMARY, RS_OK, 16'h0000));
            frame(CMD_RD_SUMMARY, got);
            check("flag reply", got, reply(OP_RD_SUMMARY, RS_PENDING, 16'h0001 << i));
            check("needs reset", {31'h0000_0000, stat_acc[2]},
                  {31'h0000_0000, |((16'h0001 << i) & 16'h0398)});
            check("crc bad", {31'h0000_0000, stat_acc[3]}, 32'h0000_0000);
            check("flag cleared", {16'h0000, sum_o}, 32'h0000_0000);
        end
        // Negative self-check value above the mode 2 limit
        @(posedge clk);
        bank1    <= 1'b1;
        self_chk <= 16'hFC00;
        reg_wr(HREG_CTRL, 32'h0000_0001);
        frame(CMD_RD_SELF_CHK, got);
        frame(CMD_RD_SELF_CHK, got);
        check("self reply", got, reply(OP_RD_SELF_CHK, RS_OK, 16'hFC00));
        frame(CMD_RD_SELF_CHK, got);
        reg_rd(HREG_STAT, got);
        check("exceed count", {24'h00_0000, got[15:8]}, 32'h0000_0002);
        reg_wr(HREG_CTRL, 32'h0000_0000);
        frame(CMD_RD_SELF_CHK, got);
        reg_rd(HREG_STAT, got);
        check("exceed reset", {24'h00_0000, got[15:8]}, 32'h0000_0000);
        // Bank 0 self-check, with a command refused while busy
        @(posedge clk);
        bank1 <= 1'b0;
        reg_wr(HREG_CMD, CMD_RD_SELF_CHK);
        reg_wr(HREG_CMD, CMD_RD_SUMMARY);
        wait_idle();
        frame(CMD_RD_SUMMARY, got);
        check("bank0 self", got, reply(OP_RD_SELF_CHK, RS_OK, 16'h0000));
        // Software reset frame from the control register
        reg_wr(HREG_CTRL, 32'h0000_0008);
        wait_idle();
        frame(CMD_RD_SUMMARY, got);
        check("reset echo", got, reply(CMD_SW_RESET[31:26], RS_OK, 16'h0000));
        print_verdict();
    end
endmodule
